// ---- logic/synth_cfg_defines.svh ----
/*
 * Offsets, field positions, reset values and codes of the configuration
 * register bank (words 1 to 3). Included by the design files; no logic.
 */
`ifndef SYNTH_CFG_DEFINES_SVH
`define SYNTH_CFG_DEFINES_SVH

// ****************************************************************
// Addresses and reset words
// ****************************************************************
`define ADDR_ZERO_WORD      3'h0
`define ADDR_MODULUS_PHASE  3'h1
`define ADDR_REF_PUMP       3'h2
`define ADDR_OSC_CLKDIV     3'h3
`define RST_MODULUS_PHASE   32'h2000FFF9
`define RST_REF_PUMP        32'h00004042
`define RST_OSC_CLKDIV      32'h0000000B

// ****************************************************************
// Field positions
// ****************************************************************
`define F_MODULUS           14:3
`define F_PIN_SRC           28:26
`define B_DOUBLER           25
`define B_HALVER            24
`define F_REF_DIV           23:14
`define B_SHADOW_EN         13
`define F_PUMP              12:9
`define B_LOCK_FN           8
`define B_PD_POL            6
`define B_POWER_DOWN        5
`define B_PUMP_TRI          4
`define B_CNT_RST           3
`define F_OSC_BAND          31:26
`define B_AUTOSEL_DIS       25
`define B_RETUNE            24
`define F_CLKDIV_MODE       16:15
`define F_CLKDIV_VAL        14:3

// ****************************************************************
// Codes
// ****************************************************************
`define TUNE_LOW            3'h0
`define TUNE_HIGH           3'h7
`define PIN_SRC_READBACK    4'hC

`endif

// ---- logic/synth_cfg_pkg.sv ----
/*
 * Types of the configuration register bank.
 * Assumes the defines header for the numbers.
 */
package synth_cfg_pkg;
    typedef enum logic [1:0] {
        CLKDIV_OFF   = 2'b00,
        CLKDIV_FAST  = 2'b01,
        CLKDIV_PHASE = 2'b10,
        CLKDIV_RSVD  = 2'b11
    } clkdiv_mode_t;

    typedef enum logic [3:0] {
        SRC_TRISTATE = 4'h0,
        SRC_HIGH     = 4'h1,
        SRC_LOW      = 4'h2,
        SRC_REFDIV   = 4'h3,
        SRC_FBDIV2   = 4'h4,
        SRC_ALOCK    = 4'h5,
        SRC_DLOCK    = 4'h6,
        SRC_READBACK = 4'hC,
        SRC_RSVD     = 4'hF
    } pin_source_t;

    typedef enum logic [0:0] {
        AS_IDLE = 1'b0,
        AS_RUN  = 1'b1
    } autosel_state_t;
endpackage : synth_cfg_pkg

// ---- logic/cfg_write_if.sv ----
/*
 * Decoded write event carried from the bank to the autoselect sequencer.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface cfg_write_if;
    logic zero_write;
    logic autosel_dis;
    logic retune_en;
    logic [2:0] tune_code;
    logic busy;
    logic start;
    modport bank (output zero_write, output autosel_dis, output retune_en,
                  output tune_code, input busy, input start);
    modport seq  (input zero_write, input autosel_dis, input retune_en,
                  input tune_code, output busy, output start);
endinterface : cfg_write_if

// ---- logic/osc_autoselect.sv ----
/*
 * Oscillator autoselect trigger and run tracker.
 * Assumes the bank drives the write event and settings; done comes from the analog side.
 */
`timescale 1ns/1ps
`include "synth_cfg_defines.svh"
module osc_autoselect (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Done from the selection engine
    input  wire logic   select_done,
    // Bank side
    cfg_write_if.seq    cw
);
    synth_cfg_pkg::autosel_state_t state;
    synth_cfg_pkg::autosel_state_t next_state;
    logic start_req;

    // ****************************************************************
    // Start request
    // ****************************************************************
    always_comb begin
        start_req = 1'b0;
        if (!cw.autosel_dis) begin
            if (cw.zero_write) begin
                start_req = 1'b1;
            end else if (cw.retune_en && state == synth_cfg_pkg::AS_IDLE &&
                         (cw.tune_code == `TUNE_LOW || cw.tune_code == `TUNE_HIGH)) begin
                start_req = 1'b1;
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            synth_cfg_pkg::AS_IDLE: begin
                if (start_req) next_state = synth_cfg_pkg::AS_RUN;
            end
            synth_cfg_pkg::AS_RUN: begin
                if (cw.autosel_dis || (select_done && !start_req)) begin
                    next_state = synth_cfg_pkg::AS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) state <= synth_cfg_pkg::AS_IDLE;
        else     state <= next_state;
    end

    assign cw.start = start_req;
    assign cw.busy  = (state == synth_cfg_pkg::AS_RUN);

    a_start_on_zero: assert property (@(posedge clk) disable iff (rst)
        (cw.zero_write && !cw.autosel_dis) |=> cw.busy)
        else $error("autoselect did not start on word 0 write");
    a_disabled_idle: assert property (@(posedge clk) disable iff (rst)
        cw.autosel_dis |-> !cw.start)
        else $error("autoselect started while disabled");
    a_retune_start: assert property (@(posedge clk) disable iff (rst)
        (!cw.autosel_dis && cw.retune_en && !cw.busy && cw.tune_code == `TUNE_HIGH)
        |-> cw.start)
        else $error("retune not started at tune rail");
endmodule : osc_autoselect

// ---- logic/synth_config_regs_1_to_3.sv ----
/*
 * Configuration bank for words 1 to 3 of the synthesizer, with shadowing
 * committed by a word 0 write. Assumes a host master on the plain port,
 * and that the tune reading and autoselect done are synchronous to clk.
 */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "synth_cfg_defines.svh"
module synth_config_regs_1_to_3 (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Register port
    input  wire logic [2:0]   addr,
    input  wire logic [31:0]  wdata,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [31:0]  rdata,
    // Inputs from the rest of the device
    input  wire logic         pin_src_msb,
    input  wire logic [2:0]   tune_code,
    input  wire logic         select_done,
    // Active configuration and autoselect busy
    output logic      [11:0]  modulus,
    output logic      [9:0]   ref_div,
    output logic      [3:0]   pump_current_code,
    output synth_cfg_pkg::pin_source_t pin_source_select,
    output logic              readback_sel,
    output logic              ref_doubler_en,
    output logic              ref_halver_en,
    output logic              shadow_commit_en,
    output logic              lock_detect_function,
    output logic              phase_detector_polarity,
    output logic              power_down,
    output logic              pump_tristate,
    output logic              counter_reset,
    output logic      [5:0]   manual_osc_band,
    output logic              manual_band_active,
    output logic              autoselect_disable,
    output logic              retune_en,
    output synth_cfg_pkg::clkdiv_mode_t clkdiv_mode,
    output logic      [11:0]  clkdiv_value,
    output logic              osc_autoselect_busy
);
    logic [31:0] word1;
    logic [31:0] word2;
    logic [31:0] word3;
    logic [31:0] next_word1;
    logic [31:0] next_word2;
    logic [31:0] next_word3;
    logic [11:0] next_modulus;
    logic [9:0]  next_ref_div;
    logic [3:0]  next_pump;
    logic [31:0] next_rdata;
    logic        zero_write;

    cfg_write_if cw ();

    // ****************************************************************
    // Write decode and shadow words
    // ****************************************************************
    assign zero_write = wr_en && addr == `ADDR_ZERO_WORD;

    always_comb begin
        next_word1 = word1;
        next_word2 = word2;
        next_word3 = word3;
        if (wr_en) begin
            unique case (addr)
                `ADDR_MODULUS_PHASE: next_word1 = wdata;
                `ADDR_REF_PUMP:      next_word2 = wdata;
                `ADDR_OSC_CLKDIV:    next_word3 = wdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Buffered fields commit on word 0 write
    // ****************************************************************
    always_comb begin
        next_modulus = modulus;
        next_ref_div = ref_div;
        next_pump    = pump_current_code;
        if (zero_write) begin
            next_modulus = word1[`F_MODULUS];
            next_ref_div = word2[`F_REF_DIV];
            next_pump    = word2[`F_PUMP];
        end
    end

    // ****************************************************************
    // Readback of stored words
    // ****************************************************************
    always_comb begin
        next_rdata = 32'h00000000;
        if (rd_en) begin
            unique case (addr)
                `ADDR_MODULUS_PHASE: next_rdata = word1;
                `ADDR_REF_PUMP:      next_rdata = word2;
                `ADDR_OSC_CLKDIV:    next_rdata = word3;
                default:             next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            word1             <= `RST_MODULUS_PHASE;
            word2             <= `RST_REF_PUMP;
            word3             <= `RST_OSC_CLKDIV;
            modulus           <= 12'hFFF;
            ref_div           <= 10'h001;
            pump_current_code <= 4'h0;
            rdata             <= 32'h00000000;
        end else begin
            word1             <= next_word1;
            word2             <= next_word2;
            word3             <= next_word3;
            modulus           <= next_modulus;
            ref_div           <= next_ref_div;
            pump_current_code <= next_pump;
            rdata             <= next_rdata;
        end
    end

    // ****************************************************************
    // Immediate fields
    // ****************************************************************
    assign pin_source_select = synth_cfg_pkg::pin_source_t'({pin_src_msb,
                                                             word2[`F_PIN_SRC]});
    assign readback_sel      = {pin_src_msb, word2[`F_PIN_SRC]} == `PIN_SRC_READBACK;
    assign ref_doubler_en          = word2[`B_DOUBLER];
    assign ref_halver_en           = word2[`B_HALVER];
    assign shadow_commit_en        = word2[`B_SHADOW_EN];
    assign lock_detect_function    = word2[`B_LOCK_FN];
    assign phase_detector_polarity = word2[`B_PD_POL];
    assign power_down              = word2[`B_POWER_DOWN];
    assign pump_tristate           = word2[`B_PUMP_TRI];
    assign counter_reset           = word2[`B_CNT_RST];
    assign manual_osc_band         = word3[`F_OSC_BAND];
    assign autoselect_disable      = word3[`B_AUTOSEL_DIS];
    assign manual_band_active      = word3[`B_AUTOSEL_DIS];
    assign retune_en               = word3[`B_RETUNE];
    assign clkdiv_mode  = synth_cfg_pkg::clkdiv_mode_t'(word3[`F_CLKDIV_MODE]);
    assign clkdiv_value = word3[`F_CLKDIV_VAL];

    // ****************************************************************
    // Autoselect sequencer
    // ****************************************************************
    assign cw.zero_write  = zero_write;
    assign cw.autosel_dis = autoselect_disable;
    assign cw.retune_en   = retune_en;
    assign cw.tune_code   = tune_code;
    assign osc_autoselect_busy = cw.busy;

    osc_autoselect u_autoselect (
        .clk         (clk),
        .rst         (rst),
        .select_done (select_done),
        .cw          (cw.seq)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_word1_write;
        wr_en && addr == `ADDR_MODULUS_PHASE;
    endsequence
    sequence s_commit;
        zero_write;
    endsequence

    a_modulus_held: assert property (@(posedge clk) disable iff (rst)
        (s_word1_write and !zero_write) |=> modulus == $past(modulus))
        else $error("modulus changed without word 0 write");
    a_modulus_commit: assert property (@(posedge clk) disable iff (rst)
        s_commit |=> modulus == $past(word1[14:3]))
        else $error("modulus not committed on word 0 write");
    a_refdiv_commit: assert property (@(posedge clk) disable iff (rst)
        s_commit |=> ref_div == $past(word2[23:14]))
        else $error("reference divider not committed");
    a_pump_commit: assert property (@(posedge clk) disable iff (rst)
        s_commit |=> pump_current_code == $past(word2[12:9]))
        else $error("pump current not committed");
    a_word2_route: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == 3'h2) |=> (counter_reset == $past(wdata[3]) &&
                                     phase_detector_polarity == $past(wdata[6])))
        else $error("word 2 not routed");
    a_word3_route: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == 3'h3) |=> clkdiv_value == $past(wdata[14:3]) &&
                                    clkdiv_mode == $past(wdata[16:15]))
        else $error("word 3 not routed");
    a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr > 3'h3) |=> (word1 == $past(word1) && word2 == $past(word2) &&
                                    word3 == $past(word3)))
        else $error("unmapped write changed state");
    a_readback_code: assert property (@(posedge clk) disable iff (rst)
        (pin_src_msb && word2[28:26] == 3'h4) |-> readback_sel)
        else $error("readback source not decoded");
    a_word2_stages: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `ADDR_REF_PUMP) |=> (ref_doubler_en == $past(wdata[25]) &&
                                             ref_halver_en == $past(wdata[24])))
        else $error("reference stage bits not routed");
    a_word2_modes: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `ADDR_REF_PUMP) |=> (shadow_commit_en == $past(wdata[13]) &&
                                             lock_detect_function == $past(wdata[8]) &&
                                             pump_tristate == $past(wdata[4])))
        else $error("word 2 mode bits not routed");
    a_word3_osc: assert property (@(posedge clk) disable iff (rst)
        (wr_en && addr == `ADDR_OSC_CLKDIV) |=> (manual_osc_band == $past(wdata[31:26]) &&
                                               retune_en == $past(wdata[24])))
        else $error("oscillator fields not routed");
    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !rd_en |=> rdata == 32'h00000000)
        else $error("read data stood beyond its cycle");
endmodule : synth_config_regs_1_to_3

// ---- tb/host_model.sv ----
/*
 * Host controller model: writes configuration words with the address in bits 2:0 (bits 23:17 cleared for word 3) and reads them back.
 * Assumes one rising-edge clock shared with the bank and no wait states.
 */
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic         clk,
    // Register port
    output logic      [2:0]   addr,
    output logic      [31:0]  wdata,
    output logic              wr_en,
    output logic              rd_en,
    input  wire logic [31:0]  rdata
);
    // Pause between programming passes, shortened for simulation
    parameter int PASS_GAP = 20;

    initial begin
        addr  = 3'h0;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    task automatic write_word(input logic [2:0] a, input logic [31:0] w);
        logic [31:0] word;
        word = {w[31:3], a};
        if (a == 3'h3) begin
            word[23:17] = 7'h00;
        end
        @(posedge clk);
        addr  <= a;
        wdata <= word;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~word;
        #1;
    endtask : write_word

    task automatic read_word(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : read_word

    // ****************************************************************
    // Sequences
    // ****************************************************************
    task automatic power_up_program(input logic [31:0] w1, input logic [31:0] w2,
                                    input logic [31:0] w3);
        repeat (2) begin
            write_word(3'h3, w3);
            write_word(3'h2, w2);
            write_word(3'h1, w1);
            write_word(3'h0, 32'h0);
            repeat (PASS_GAP) @(posedge clk);
        end
    endtask : power_up_program

    task automatic phase_shift(input logic [31:0] w1, input logic [31:0] w3);
        write_word(3'h1, w1);
        write_word(3'h3, {w3[31:17], 2'b10, w3[14:0]});
        write_word(3'h3, {w3[31:17], 2'b00, w3[14:0]});
    endtask : phase_shift
endmodule : host_model

// ---- tb/tb.sv ----
/*
 * Self-checking bench of the configuration bank, words 1 to 3.
 * Assumes the host model drives the register port; the bench drives the rest.
 */
`timescale 1ns/1ps
`include "synth_cfg_defines.svh"
module tb;
    logic                         clk, rst, wr_en, rd_en, pin_src_msb, select_done;
    logic        [2:0]            addr, tune_code;
    logic        [31:0]           wdata, rdata, lfsr;
    logic        [11:0]           modulus, clkdiv_value;
    logic        [9:0]            ref_div;
    logic        [3:0]            pump_current_code;
    logic        [5:0]            manual_osc_band;
    logic                         readback_sel, ref_doubler_en, ref_halver_en;
    logic                         shadow_commit_en, lock_detect_function, power_down;
    logic                         phase_detector_polarity, pump_tristate, counter_reset;
    logic                         manual_band_active, autoselect_disable, retune_en;
    logic                         osc_autoselect_busy;
    synth_cfg_pkg::pin_source_t   pin_source_select;
    synth_cfg_pkg::clkdiv_mode_t  clkdiv_mode;
    int                           fail_count = 0;
    int                           checks = 0;
    int                           cycles = 0;

    host_model host_model_i (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));

    synth_config_regs_1_to_3 synth_config_regs_1_to_3_i (.clk(clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .pin_src_msb(pin_src_msb), .tune_code(tune_code), .select_done(select_done),
        .modulus(modulus), .ref_div(ref_div), .pump_current_code(pump_current_code),
        .pin_source_select(pin_source_select), .readback_sel(readback_sel),
        .ref_doubler_en(ref_doubler_en), .ref_halver_en(ref_halver_en),
        .shadow_commit_en(shadow_commit_en), .lock_detect_function(lock_detect_function),
        .phase_detector_polarity(phase_detector_polarity), .power_down(power_down),
        .pump_tristate(pump_tristate), .counter_reset(counter_reset),
        .manual_osc_band(manual_osc_band), .manual_band_active(manual_band_active),
        .autoselect_disable(autoselect_disable), .retune_en(retune_en),
        .clkdiv_mode(clkdiv_mode), .clkdiv_value(clkdiv_value),
        .osc_autoselect_busy(osc_autoselect_busy));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    function automatic logic [31:0] exp_word(input logic [2:0] a, input logic [31:0] w);
        exp_word = {w[31:3], a};
        if (a == 3'h3) begin
            exp_word[23:17] = 7'h00;
        end
    endfunction : exp_word

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic check_fields(input logic [31:0] w2, input logic [31:0] w3);
        chk("pin_source", {pin_src_msb, w2[28:26]}, pin_source_select);
        chk("readback_sel", {pin_src_msb, w2[28:26]} == 4'hC, readback_sel);
        chk("ref_stages", {w2[25], w2[24]}, {ref_doubler_en, ref_halver_en});
        chk("shadow_en", w2[13], shadow_commit_en);
        chk("lock_fn", w2[8], lock_detect_function);
        chk("pd_pol", w2[6], phase_detector_polarity);
        chk("power_down", w2[5], power_down);
        chk("pump_tri", w2[4], pump_tristate);
        chk("cnt_rst", w2[3], counter_reset);
        chk("osc_band", {w3[31:25]}, {manual_osc_band, manual_band_active});
        chk("as_dis", w3[25], autoselect_disable);
        chk("retune", w3[24], retune_en);
        chk("cd_mode", w3[16:15], clkdiv_mode);
        chk("cd_val", w3[14:3], clkdiv_value);
    endtask : check_fields

    task automatic check_active(input logic [31:0] w1, input logic [31:0] w2);
        chk("modulus", w1[14:3], modulus);
        chk("ref_div", w2[23:14], ref_div);
        chk("pump", w2[12:9], pump_current_code);
    endtask : check_active

    task automatic wait_busy(input logic exp);
        int n;
        n = 0;
        while (osc_autoselect_busy !== exp && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("busy", exp, osc_autoselect_busy);
    endtask : wait_busy

    task automatic pulse_done();
        @(posedge clk) select_done <= 1'b1;
        @(posedge clk) select_done <= 1'b0;
    endtask : pulse_done

    task automatic conclude();
        if (fail_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] w1, w2, w3, a1, a2, d;
        logic [2:0]  j;
        rst = 1'b1;
        pin_src_msb = 1'b0;
        tune_code = 3'h2;
        select_done = 1'b0;
        lfsr = 32'hD378;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_active(`RST_MODULUS_PHASE, `RST_REF_PUMP);
        check_fields(`RST_REF_PUMP, `RST_OSC_CLKDIV);
        chk("busy", 1'b0, osc_autoselect_busy);
        for (j = 3'h1; j <= 3'h3; j++) begin
            host_model_i.read_word(j, d);
            chk("reset_word", j == 3'h1 ? `RST_MODULUS_PHASE : j == 3'h2 ? `RST_REF_PUMP
                : `RST_OSC_CLKDIV, d);
        end
        a1 = rnd() | 32'h10;
        a2 = rnd() | 32'h4000;
        host_model_i.power_up_program(a1, a2, 32'h0200_0008);
        check_active(a1, a2);
        for (int i = 0; i < 12; i++) begin
            w1 = rnd() | 32'h10;
            w2 = rnd() | 32'h4000;
            w3 = exp_word(3'h3, rnd() | 32'h0200_0008);
            if (i == 0) w2[28:26] = 3'h4;
            if (i == 1) {w1[14:3], w2[23:14], w3[14:3]} = {12'hFFF, 10'h3FF, 12'hFFF};
            if (i == 2) {w1[14:3], w2[23:14], w3[14:3]} = {12'h002, 10'h001, 12'h001};
            @(posedge clk) pin_src_msb <= (i == 0) ? 1'b1 : w1[0];
            host_model_i.write_word(3'h1, w1);
            host_model_i.write_word(3'h2, w2);
            host_model_i.write_word(3'h3, w3);
            check_fields(w2, w3);
            check_active(a1, a2);
            for (j = 3'h1; j <= 3'h3; j++) begin
                host_model_i.read_word(j, d);
                chk("readback", exp_word(j, j == 3'h1 ? w1 : j == 3'h2 ? w2 : w3), d);
            end
            j = 3'h4 + {1'b0, i[1:0]};
            host_model_i.write_word(j, rnd());
            host_model_i.read_word(j, d);
            chk("unmapped", 32'h0, d);
            check_fields(w2, w3);
            check_active(a1, a2);
            host_model_i.write_word(3'h0, 32'h0);
            a1 = w1;
            a2 = w2;
            check_active(a1, a2);
            chk("busy", 1'b0, osc_autoselect_busy);
        end
        for (int m = 0; m < 4; m++) begin
            host_model_i.write_word(3'h3, 32'h0200_0008 | (m << 15));
            chk("cd_mode", m[1:0], clkdiv_mode);
        end
        host_model_i.phase_shift(a1 | 32'h0000_8000, 32'h0200_0008);
        chk("cd_mode", 2'b00, clkdiv_mode);
        host_model_i.write_word(3'h3, 32'h0000_000B);
        host_model_i.write_word(3'h0, 32'h0);
        wait_busy(1'b1);
        pulse_done();
        wait_busy(1'b0);
        host_model_i.write_word(3'h3, 32'h0100_000B);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) tune_code <= (k == 0) ? 3'h0 : 3'h7;
            wait_busy(1'b1);
            @(posedge clk) tune_code <= 3'h2;
            pulse_done();
            wait_busy(1'b0);
        end
        @(posedge clk) tune_code <= 3'h3;
        repeat (4) @(posedge clk);
        #1;
        chk("busy", 1'b0, osc_autoselect_busy);
        host_model_i.write_word(3'h3, 32'h0200_000B);
        host_model_i.write_word(3'h0, 32'h0);
        repeat (4) @(posedge clk);
        #1;
        chk("busy", 1'b0, osc_autoselect_busy);
        conclude();
    end
endmodule : tb
